// *** design/spfc_map.svh ***
`ifndef SPFC_MAP_SVH
`define SPFC_MAP_SVH
// register byte addresses
`define SPFC_CTRL_ADDR 8'h00
`define SPFC_POINTER_ADDR 8'h04
`define SPFC_DATA_ADDR 8'h08
`define SPFC_STATUS_ADDR 8'h0C
`define SPFC_LOCK_ADDR 8'h10
`define SPFC_FUSE_ADDR 8'h14
// control field positions
`define SPFC_BIT_STORE_EN 0
`define SPFC_BIT_ERASE 1
`define SPFC_BIT_WRITE 2
`define SPFC_BIT_LKSET 3
`define SPFC_BIT_RWWRE 4
`define SPFC_BIT_RSVD 5
`define SPFC_BIT_BUSY 6
`define SPFC_BIT_IRQEN 7
// command patterns in the low five bits
`define SPFC_CMD_REEN 5'h11
`define SPFC_CMD_LOCK 5'h09
`define SPFC_CMD_WRITE 5'h05
`define SPFC_CMD_ERASE 5'h03
`define SPFC_CMD_LOAD 5'h01
// reset values
`define SPFC_CTRL_RESET 8'h00
`define SPFC_LOCK_RESET 8'hFF
// timing
`define SPFC_WINDOW_CYCLES 3'h4
`define SPFC_FUSE_WIN_CYCLES 3'h3
`define SPFC_CLK_NS 50
`define SPFC_PROG_TIME_NS 4000
`define SPFC_PROG_CYCLES ((`SPFC_PROG_TIME_NS + `SPFC_CLK_NS - 1) / `SPFC_CLK_NS)
// geometry
`define SPFC_WORD_BITS 6
`define SPFC_PAGE_BITS 8
`define SPFC_PAGE_WORDS 64
`define SPFC_HALT_FIRST_PAGE 8'hE0
`endif

// *** design/spfc_pkg.sv ***
package spfc_pkg;
    typedef enum logic [2:0] {
        SPFC_IDLE,
        SPFC_ARMED,
        SPFC_BUSY
    } spfc_state_t;
    typedef enum logic [2:0] {
        SPFC_OP_NONE,
        SPFC_OP_LOAD,
        SPFC_OP_ERASE,
        SPFC_OP_WRITE,
        SPFC_OP_LOCK,
        SPFC_OP_REEN
    } spfc_op_t;
    typedef struct packed {
        logic [7:0] page;
        logic erase;
        logic write;
    } spfc_flash_req_t;
endpackage : spfc_pkg

// *** design/spfc_top.sv ***
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "spfc_map.svh"
// Notes on behaviour
// (R1) ready interrupt requested while enable and global flag set and store-enable is zero
// (R2) erase or write to shared region sets busy flag and blocks region access
// (R3) busy clears by re-enable after completion, or when a buffer load starts
// (R4) control bit 5 always reads zero
// (R5) re-enable with store-enable then store within four clocks re-enables region
// (R6) re-enable refused while erase or write still runs
// (R7) re-enable during buffer loading discards all buffered data
// (R8) lock-set command plus store programs lock bits from low data byte
// (R9) lock-set clears after programming or when four clocks pass unused
// (R10) load within three clocks after lock-set returns lock or fuse bits
// (R11) page-write command plus store writes buffer into pointer page
// (R12) page-write clears when write ends or window expires
// (R13) page-erase command plus store erases page; clears at end or expiry
// (R14) core halted during erase or write to the non-shared region
// (R15) plain store-enable store puts data pair into buffer word by pointer
// (R16) store-enable clears after store or expiry, stays high during erase/write
// (R17) only the five command patterns take effect; others ignored
// (R18) pointer splits page and word; address latched at operation start
// (R19) load instruction addresses bytewise, pointer bit zero picks byte
// (R20) software erases before writing, same page address for both
// (R21) buffer loads accepted one word at a time in any order
// (R22) buffer cleared after write, re-enable and reset; one write per word
// (R23) data-memory write during loading discards loaded data
// (R24) control resets to zero; busy bit read-only
// (R25) arming window counted from the cycle the control write takes effect
module spfc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic global_irq_flag,
    input wire logic store_program_instruction,
    input wire logic load_program_instruction,
    input wire logic eeprom_write,
    output logic program_ready_irq,
    output logic core_halt,
    output logic rww_region_blocked,
    output logic [7:0] load_result
);
    logic [7:0] ctrl_ff;
    logic [15:0] pointer_ff;
    logic [15:0] data_register_pair_ff;
    logic [7:0] lock_ff;
    logic [7:0] fuse_ff;
    logic [2:0] win_ff;
    logic [2:0] fuse_win_ff;
    logic [12:0] prog_cnt_ff;
    spfc_pkg::spfc_state_t state_ff;
    spfc_pkg::spfc_flash_req_t req_ff;
    logic loading_ff;
    logic [15:0] buf_mem [0:`SPFC_PAGE_WORDS-1];
    logic [`SPFC_PAGE_WORDS-1:0] buf_used_ff;
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_go;
    logic ctrl_wr;
    logic [4:0] cmd;
    logic cmd_ok;
    logic store_fire;
    spfc_pkg::spfc_op_t op;

    // page and word fields of the pointer
    function automatic logic [7:0] page_of(input logic [15:0] ptr); // [R18]
        page_of = ptr[`SPFC_WORD_BITS+`SPFC_PAGE_BITS:`SPFC_WORD_BITS+1];
    endfunction : page_of

    function automatic logic [5:0] word_of(input logic [15:0] ptr);
        word_of = ptr[`SPFC_WORD_BITS:1]; // lsb ignored [R15]
    endfunction : word_of

    // axi write channel capture, either order
    assign wr_go = aw_ff && w_ff && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_ff == `SPFC_CTRL_ADDR || awaddr_ff == `SPFC_POINTER_ADDR ||
                    awaddr_ff == `SPFC_DATA_ADDR) begin
                    s_axi_bresp <= 2'h0;
                end else begin
                    s_axi_bresp <= 2'h2;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // command decode of a control write
    assign ctrl_wr = wr_go && awaddr_ff == `SPFC_CTRL_ADDR && wstrb_ff[0];
    assign cmd = wdata_ff[4:0];
    always_comb begin
        op = spfc_pkg::SPFC_OP_NONE;
        if (cmd == `SPFC_CMD_LOAD) begin
            op = spfc_pkg::SPFC_OP_LOAD;
        end else if (cmd == `SPFC_CMD_ERASE) begin
            op = spfc_pkg::SPFC_OP_ERASE;
        end else if (cmd == `SPFC_CMD_WRITE) begin
            op = spfc_pkg::SPFC_OP_WRITE;
        end else if (cmd == `SPFC_CMD_LOCK) begin
            op = spfc_pkg::SPFC_OP_LOCK;
        end else if (cmd == `SPFC_CMD_REEN) begin
            op = spfc_pkg::SPFC_OP_REEN;
        end
    end
    // commands only while idle; re-enable refused while busy
    assign cmd_ok = ctrl_wr && op != spfc_pkg::SPFC_OP_NONE &&
                    state_ff == spfc_pkg::SPFC_IDLE; // [R17] [R6]
    assign store_fire = store_program_instruction && state_ff == spfc_pkg::SPFC_ARMED;

    // pointer and data pair registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pointer_ff <= 16'h0000;
            data_register_pair_ff <= 16'h0000;
        end else if (wr_go && awaddr_ff == `SPFC_POINTER_ADDR) begin
            pointer_ff <= wdata_ff[15:0];
        end else if (wr_go && awaddr_ff == `SPFC_DATA_ADDR) begin
            data_register_pair_ff <= wdata_ff[15:0];
        end
    end

    // sequencer: arm window, busy period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= spfc_pkg::SPFC_IDLE;
            ctrl_ff <= `SPFC_CTRL_RESET; // [R24]
            win_ff <= 3'h0;
            prog_cnt_ff <= 13'h0000;
            req_ff <= '0;
        end else begin
            if (ctrl_wr) begin
                ctrl_ff[`SPFC_BIT_IRQEN] <= wdata_ff[`SPFC_BIT_IRQEN];
            end
            case (state_ff)
                spfc_pkg::SPFC_IDLE: begin
                    if (cmd_ok) begin
                        ctrl_ff[4:0] <= cmd;
                        win_ff <= `SPFC_WINDOW_CYCLES; // [R25]
                        state_ff <= spfc_pkg::SPFC_ARMED;
                    end
                end
                spfc_pkg::SPFC_ARMED: begin
                    if (store_fire) begin
                        if (ctrl_ff[`SPFC_BIT_ERASE] || ctrl_ff[`SPFC_BIT_WRITE]) begin
                            // latch address, stay enabled while programming [R18] [R16]
                            req_ff.page <= page_of(pointer_ff); // [R11] [R13]
                            req_ff.erase <= ctrl_ff[`SPFC_BIT_ERASE];
                            req_ff.write <= ctrl_ff[`SPFC_BIT_WRITE];
                            prog_cnt_ff <= 13'(`SPFC_PROG_CYCLES);
                            state_ff <= spfc_pkg::SPFC_BUSY;
                            if (page_of(pointer_ff) < `SPFC_HALT_FIRST_PAGE) begin
                                ctrl_ff[`SPFC_BIT_BUSY] <= 1'b1; // [R2]
                            end
                        end else begin
                            if (ctrl_ff[`SPFC_BIT_RWWRE]) begin
                                ctrl_ff[`SPFC_BIT_BUSY] <= 1'b0; // [R3] [R5]
                            end else if (ctrl_ff[4:0] == `SPFC_CMD_LOAD) begin
                                ctrl_ff[`SPFC_BIT_BUSY] <= 1'b0; // [R3]
                            end
                            ctrl_ff[4:0] <= 5'h00; // [R9] [R16]
                            state_ff <= spfc_pkg::SPFC_IDLE;
                        end
                    end else if (win_ff == 3'h1) begin
                        ctrl_ff[4:0] <= 5'h00; // window expired [R9] [R12] [R13] [R16]
                        state_ff <= spfc_pkg::SPFC_IDLE;
                    end else begin
                        win_ff <= win_ff - 3'h1;
                    end
                end
                spfc_pkg::SPFC_BUSY: begin
                    if (prog_cnt_ff == 13'h0001) begin
                        ctrl_ff[4:0] <= 5'h00; // [R12] [R13] [R16]
                        req_ff <= '0;
                        state_ff <= spfc_pkg::SPFC_IDLE;
                    end else begin
                        prog_cnt_ff <= prog_cnt_ff - 13'h0001;
                    end
                end
                default: begin
                    state_ff <= spfc_pkg::SPFC_IDLE;
                end
            endcase
        end
    end

    // temporary page buffer with one-write-per-word tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_used_ff <= '0; // [R22]
            loading_ff <= 1'b0;
        end else if (state_ff == spfc_pkg::SPFC_ARMED && store_fire &&
                     ctrl_ff[`SPFC_BIT_RWWRE]) begin
            buf_used_ff <= '0; // [R7] [R22]
            loading_ff <= 1'b0;
        end else if (eeprom_write && loading_ff) begin
            buf_used_ff <= '0; // [R23]
            loading_ff <= 1'b0;
        end else if (state_ff == spfc_pkg::SPFC_BUSY && prog_cnt_ff == 13'h0001 &&
                     req_ff.write) begin
            buf_used_ff <= '0; // [R22]
            loading_ff <= 1'b0;
        end else if (store_fire && ctrl_ff[4:0] == `SPFC_CMD_LOAD) begin
            buf_used_ff[word_of(pointer_ff)] <= 1'b1; // [R21]
            loading_ff <= 1'b1;
        end
    end

    // buffer word storage, first write per word only
    always_ff @(posedge aclk) begin
        if (store_fire && ctrl_ff[4:0] == `SPFC_CMD_LOAD &&
            !buf_used_ff[word_of(pointer_ff)]) begin
            buf_mem[word_of(pointer_ff)] <= data_register_pair_ff; // [R15] [R22]
        end
    end

    // lock bits and fuses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_ff <= `SPFC_LOCK_RESET;
            fuse_ff <= `SPFC_LOCK_RESET;
        end else if (store_fire && ctrl_ff[`SPFC_BIT_LKSET]) begin
            lock_ff <= lock_ff & data_register_pair_ff[7:0]; // low byte only [R8]
        end
    end

    // load instruction read window and result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_win_ff <= 3'h0;
            load_result <= 8'h00;
        end else begin
            if (cmd_ok && op == spfc_pkg::SPFC_OP_LOCK) begin
                fuse_win_ff <= `SPFC_FUSE_WIN_CYCLES; // [R10]
            end else if (fuse_win_ff != 3'h0) begin
                fuse_win_ff <= fuse_win_ff - 3'h1;
            end
            if (load_program_instruction) begin
                if (fuse_win_ff != 3'h0) begin
                    load_result <= pointer_ff[0] ? fuse_ff : lock_ff; // [R10]
                end else begin
                    load_result <= pointer_ff[0] ? buf_mem[word_of(pointer_ff)][15:8] :
                                   buf_mem[word_of(pointer_ff)][7:0]; // [R19]
                end
            end
        end
    end

    // status outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_ready_irq <= 1'b0;
            core_halt <= 1'b0;
            rww_region_blocked <= 1'b0;
        end else begin
            program_ready_irq <= ctrl_ff[`SPFC_BIT_IRQEN] && global_irq_flag &&
                                 !ctrl_ff[`SPFC_BIT_STORE_EN]; // [R1]
            core_halt <= state_ff == spfc_pkg::SPFC_BUSY &&
                         req_ff.page >= `SPFC_HALT_FIRST_PAGE; // [R14]
            rww_region_blocked <= ctrl_ff[`SPFC_BIT_BUSY]; // [R2]
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                s_axi_rdata <= 32'h0000_0000;
                if (s_axi_araddr == `SPFC_CTRL_ADDR) begin
                    s_axi_rdata[7:0] <= ctrl_ff & 8'hDF; // [R4]
                end else if (s_axi_araddr == `SPFC_POINTER_ADDR) begin
                    s_axi_rdata[15:0] <= pointer_ff;
                end else if (s_axi_araddr == `SPFC_DATA_ADDR) begin
                    s_axi_rdata[15:0] <= data_register_pair_ff;
                end else if (s_axi_araddr == `SPFC_STATUS_ADDR) begin
                    s_axi_rdata[2:0] <= state_ff;
                end else if (s_axi_araddr == `SPFC_LOCK_ADDR) begin
                    s_axi_rdata[7:0] <= lock_ff;
                end else if (s_axi_araddr == `SPFC_FUSE_ADDR) begin
                    s_axi_rdata[7:0] <= fuse_ff;
                end else begin
                    s_axi_rresp <= 2'h2;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_ff[7] && global_irq_flag && !ctrl_ff[0] |=> program_ready_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("ready irq missing"); // [R1]
    property p_busy_set;
        @(posedge aclk) disable iff (!aresetn)
        store_fire && ctrl_ff[1] && page_of(pointer_ff) < 8'hE0 |=> ctrl_ff[6];
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set"); // [R2]
    property p_load_clr;
        @(posedge aclk) disable iff (!aresetn)
        store_fire && ctrl_ff[4:0] == 5'h01 |=> !ctrl_ff[6];
    endproperty
    a_load_clr: assert property (p_load_clr) else $error("busy not cleared"); // [R3]
    property p_rsvd;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SPFC_CTRL_ADDR |=> !s_axi_rdata[5];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // [R4]
    property p_expire;
        @(posedge aclk) disable iff (!aresetn)
        cmd_ok ##1 !store_program_instruction [*4] |=> !ctrl_ff[0];
    endproperty
    a_expire: assert property (p_expire) else $error("window overrun"); // [R16]
    property p_held;
        @(posedge aclk) disable iff (!aresetn)
        state_ff == spfc_pkg::SPFC_BUSY |-> ctrl_ff[0];
    endproperty
    a_held: assert property (p_held) else $error("enable dropped"); // [R16]
    property p_ignore;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_wr && op == spfc_pkg::SPFC_OP_NONE && state_ff == spfc_pkg::SPFC_IDLE
        |=> state_ff == spfc_pkg::SPFC_IDLE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("bad pattern took effect"); // [R17]
    property p_halt;
        @(posedge aclk) disable iff (!aresetn)
        state_ff == spfc_pkg::SPFC_BUSY && req_ff.page >= 8'hE0 |=> core_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("core not halted"); // [R14]
    c_load: cover property (@(posedge aclk) store_fire && ctrl_ff[4:0] == 5'h01);
    c_erase: cover property (@(posedge aclk) state_ff == spfc_pkg::SPFC_BUSY);
    c_lock: cover property (@(posedge aclk) store_fire && ctrl_ff[3]);
endmodule : spfc_top

// *** verif/spfc_core_model.sv ***
`timescale 1ns/10ps
// core side: store or load pulses on request, promptly or one cycle late
module spfc_core_model (
    input logic aclk,
    input logic aresetn,
    input logic op_req,
    input logic op_load,
    input logic op_delay,
    input logic core_halt,
    output logic store_program_instruction,
    output logic load_program_instruction,
    output logic op_done
);
    logic pend_ff;
    logic load_ff;
    logic fire;
    // a halted core issues nothing until released
    assign fire = !core_halt && ((op_req && !op_delay) || (pend_ff && !op_req));
    // one-cycle instruction pulse and completion flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_ff <= 1'b0;
            load_ff <= 1'b0;
            store_program_instruction <= 1'b0;
            load_program_instruction <= 1'b0;
            op_done <= 1'b0;
        end else begin
            store_program_instruction <= fire && !(op_req ? op_load : load_ff);
            load_program_instruction <= fire && (op_req ? op_load : load_ff);
            op_done <= fire;
            if (op_req) begin
                load_ff <= op_load;
            end
            pend_ff <= !fire && (op_req || pend_ff);
        end
    end
endmodule : spfc_core_model

// *** verif/spfc_top_bench.sv ***
`timescale 1ns/10ps
`include "spfc_map.svh"
module spfc_top_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, load_result, x;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic global_irq_flag, store_program_instruction, load_program_instruction, eeprom_write;
    logic program_ready_irq, core_halt, rww_region_blocked, op_req, op_load, op_delay, op_done;
    int fail_count, cmp_count;
    logic [7:0] cmds [4] = '{8'h89, 8'h85, 8'h83, 8'h81};
    localparam logic [7:0] CT = `SPFC_CTRL_ADDR;
    localparam logic [7:0] PT = `SPFC_POINTER_ADDR;

    spfc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_irq_flag,
        .store_program_instruction, .load_program_instruction, .eeprom_write,
        .program_ready_irq, .core_halt, .rww_region_blocked, .load_result);
    spfc_core_model i_core (.aclk, .aresetn, .op_req, .op_load, .op_delay, .core_halt,
        .store_program_instruction, .load_program_instruction, .op_done);

    // 20 mhz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic hang();
        fail_count++;
        $display("ERROR wait expected answer seen timeout");
        end_of_test();
    endtask : hang

    // write one word; address and data channels released separately
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, got;
        aw = 1'b1;
        w = 1'b1;
        got = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                got = 1'b1;
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (!got) hang();
        chk("bresp", {30'h0, er}, {30'h0, rsp});
    endtask : wr

    // read one word and compare
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                got = 1'b1;
                rv = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
        if (!got) hang();
        chk("rresp", {30'h0, er}, {30'h0, rsp});
        if (er == 2'h0) chk("rdata", e, rv);
    endtask : rd

    // core instruction, waits for the pulse
    task automatic op(input logic ld, input logic dl);
        logic got;
        got = 1'b0;
        op_req <= 1'b1;
        op_load <= ld;
        op_delay <= dl;
        @(posedge aclk);
        op_req <= 1'b0;
        for (int n = 0; n < 300 && !got; n++) begin
            @(posedge aclk);
            got = op_done;
        end
        if (!got) hang();
    endtask : op

    task automatic cmd(input logic [7:0] c, input logic dl);
        wr(CT, {24'h0, c}, 2'h0);
        op(1'b0, dl);
        repeat (2) @(posedge aclk);
    endtask : cmd

    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {global_irq_flag, eeprom_write, op_req, op_load, op_delay} = 5'h10;
        fail_count = 0;
        cmp_count = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CT, 32'h0, 2'h0);
        rd(`SPFC_LOCK_ADDR, 32'hFF, 2'h0);
        rd(8'h18, 32'h0, 2'h2);
        wr(`SPFC_STATUS_ADDR, 32'h1, 2'h2);
        wr(CT, 32'hE7, 2'h0);
        rd(CT, 32'h80, 2'h0);
        chk("irq", 32'h1, {31'h0, program_ready_irq});
        $display("test reset and access done");
        foreach (cmds[i]) begin
            wr(CT, {24'h0, cmds[i]}, 2'h0);
            repeat (8) @(posedge aclk);
            rd(CT, 32'h80, 2'h0);
        end
        $display("test window expiry done");
        wr(PT, 32'h0800, 2'h0);
        cmd(8'h83, 1'b1);
        wr(PT, 32'h7000, 2'h0);
        chk("blocked", 32'h1, {31'h0, rww_region_blocked});
        chk("irq", 32'h0, {31'h0, program_ready_irq});
        chk("halt", 32'h0, {31'h0, core_halt});
        rd(CT, 32'hC3, 2'h0);
        cmd(8'h91, 1'b0);
        rd(CT, 32'hC3, 2'h0);
        repeat (100) @(posedge aclk);
        rd(CT, 32'hC0, 2'h0);
        chk("irq", 32'h1, {31'h0, program_ready_irq});
        cmd(8'h91, 1'b1);
        chk("blocked", 32'h0, {31'h0, rww_region_blocked});
        rd(CT, 32'h80, 2'h0);
        $display("test erase and re-enable done");
        eeprom_write <= 1'b1;
        @(posedge aclk);
        eeprom_write <= 1'b0;
        for (int i = 3; i >= 0; i--) begin
            wr(PT, 32'h0801 + 32'(i * 2), 2'h0);
            wr(`SPFC_DATA_ADDR, 32'h1000 + 32'(i), 2'h0);
            cmd(8'h81, 1'(i));
            rd(CT, 32'h80, 2'h0);
        end
        wr(PT, 32'h0802, 2'h0);
        cmd(8'h81, 1'b0);
        op(1'b1, 1'b0);
        @(posedge aclk);
        chk("load_byte", 32'h01, {24'h0, load_result});
        eeprom_write <= 1'b1;
        @(posedge aclk);
        eeprom_write <= 1'b0;
        cmd(8'h81, 1'b0);
        op(1'b1, 1'b0);
        @(posedge aclk);
        chk("load_byte", 32'h00, {24'h0, load_result});
        wr(PT, 32'h0800, 2'h0);
        cmd(8'h85, 1'b0);
        chk("blocked", 32'h1, {31'h0, rww_region_blocked});
        rd(CT, 32'hC5, 2'h0);
        repeat (100) @(posedge aclk);
        rd(CT, 32'hC0, 2'h0);
        cmd(8'h81, 1'b0);
        chk("blocked", 32'h0, {31'h0, rww_region_blocked});
        $display("test load and page write done");
        wr(PT, 32'h7000, 2'h0);
        cmd(8'h83, 1'b0);
        chk("halt", 32'h1, {31'h0, core_halt});
        rd(CT, 32'h83, 2'h0);
        op(1'b0, 1'b0);
        chk("halt", 32'h0, {31'h0, core_halt});
        rd(CT, 32'h80, 2'h0);
        $display("test halting erase done");
        wr(PT, 32'hFFFF, 2'h0);
        wr(`SPFC_DATA_ADDR, 32'h00F3, 2'h0);
        cmd(8'h89, 1'b0);
        rd(CT, 32'h80, 2'h0);
        rd(`SPFC_LOCK_ADDR, 32'hF3, 2'h0);
        wr(PT, 32'h0, 2'h0);
        wr(CT, 32'h89, 2'h0);
        op(1'b1, 1'b0);
        repeat (2) @(posedge aclk);
        x = load_result;
        repeat (8) @(posedge aclk);
        wr(PT, 32'h1, 2'h0);
        wr(CT, 32'h89, 2'h0);
        op(1'b1, 1'b0);
        repeat (2) @(posedge aclk);
        chk("lock_fuse", 32'h1, {31'h0, (x == 8'hF3 && load_result == 8'hFF)
            || (x == 8'hFF && load_result == 8'hF3)});
        global_irq_flag <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, program_ready_irq});
        $display("test lock bits done");
        end_of_test();
    end
endmodule : spfc_top_bench
